/* include/pss_pkg.sv */
// constants, encodings and register map of the pi sleep and snooze supervisor
// assumes a 100 MHz core clock; percent values are in 0.01 % steps
package pss_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 100;                   // core clock rate
    localparam int TICK_MS = 100;                   // control tick period
    localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ; // cycles per tick
    localparam int TICKS_PER_S = 1000 / TICK_MS;    // ticks in one second
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] REG_STATUS = 4'h0;       // block state readback
    localparam logic [3:0] REG_NET_SP = 4'h6;       // network_pi_setpoint
    localparam logic [3:0] REG_NET_SEL = 4'hF;      // network_setpoint_select
    localparam int NET_SEL_BIT = 1;                 // use network setpoint
    localparam logic [15:0] NET_RST = 16'h0000;     // register reset value
    // ************************************************************
    // scaling
    // ************************************************************
    localparam int FULL_PCT = 10000;                // 100.00 %
    localparam int PCT_MUL = 100;                   // whole % to 0.01 %
    localparam int GAIN_DIV = 10;                   // gain in 0.1 steps
    localparam int HZ_DIV = 1000;                   // pct*dHz to 0.01 Hz
    localparam int RPM_MUL = 12;                    // 120 / 100000 ...
    localparam int RPM_DIV = 10000;                 // ... reduced
    localparam int ENG_DIV = 10000;                 // digit 5 splits here
    localparam logic [15:0] DISP_HZ = 16'h0000;     // 0.01 Hz steps
    localparam logic [15:0] DISP_PCT = 16'h0001;    // percent
    localparam logic [15:0] DISP_ENG = 16'h0028;    // 40 and up
    // ************************************************************
    // selector encodings
    // ************************************************************
    localparam logic [1:0] PI_OFF = 2'h0;           // pi disabled
    localparam logic [1:0] PI_ON = 2'h1;            // pi forms command
    localparam logic [1:0] PI_TRIM = 2'h3;          // pi trims command
    localparam logic [1:0] LOSS_OFF = 2'h0;         // loss ignored
    localparam logic [1:0] LOSS_ALM = 2'h1;         // loss flagged only
    localparam logic [1:0] LOSS_FLT = 2'h2;         // loss coasts, faults
    localparam logic [1:0] SRC_CMD = 2'h0;          // post-pi command
    localparam logic [1:0] SRC_SP = 2'h1;           // setpoint
    localparam logic [1:0] SRC_SNZ = 2'h2;          // snooze behaviour
    localparam logic [1:0] FMT_HZ = 2'h0;           // monitor format codes
    localparam logic [1:0] FMT_PCT = 2'h1;
    localparam logic [1:0] FMT_RPM = 2'h2;
    localparam logic [1:0] FMT_ENG = 2'h3;
    typedef enum logic [2:0] {
        PSS_NORM = 3'h1,
        PSS_BOOST = 3'h2,
        PSS_SNZ = 3'h4
    } pss_snz_type;
endpackage

/* logic/pss_supervisor.sv */
// pi output shaping, setpoint selection and ramp, feedback loss, sleep,
// snooze with boost, and monitor scaling for a motor drive
// assumes pi result, feedback and speed values arrive on core_clk_i;
// only the run pin comes from outside and is synchronised here
//
// Contract
// - pi result times output gain
// - no reverse unless permitted under pi
// - alarm mode flags loss, keeps running
// - fault mode coasts and sets relay
// - loss after feedback low for time
// - sleep only with nonzero start level
// - low for delay drops run, output
// - asleep stops both run and the output drive
// - wake after above level for delay
// - sleep works with pi disabled
// - setpoint changes ramp over set time
// - stored, network or speed setpoint source
// - differential mode ignores stored setpoint
// - scaling selects monitor format
// - eng units: four digits, decimal places
// - scaling changes presentation only
// - sleep source command, setpoint, snooze
// - freq low for delay shuts output
// - wake from snooze on low feedback
// - boost setpoint before snooze, then restore
// - boost timeout forces snooze
// - snooze needs both conditions, instant wake
`timescale 1ns/1ps
module pss_supervisor import pss_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC,           // cycles per control tick
    parameter int MAX_FREQ_DHZ = 600                // max freq, 0.1 Hz
) (
    input wire logic core_clk_i,                    // core clock
    input wire logic nrst_i,                        // async reset, low
    input wire logic ce_i,                          // clock enable
    input wire logic run_pin_i,                     // external run, async
    input wire logic fault_reset_i,                 // clears loss fault
    input wire logic signed [15:0] pi_result_i,     // pi core out, 0.01 %
    input wire logic signed [15:0] speed_ref_i,     // active speed command
    input wire logic [15:0] feedback_i,             // feedback, 0.01 %
    input wire logic [15:0] out_freq_i,             // output freq, 0.01 %
    input wire logic [1:0] pi_mode_select_i,        // pi mode
    input wire logic diff_mode_i,                   // differential feedback
    input wire logic [7:0] pi_output_gain_i,        // 0.1 steps
    input wire logic pi_reverse_permit_i,           // allow reverse
    input wire logic [1:0] feedback_loss_response_i, // loss response
    input wire logic [6:0] feedback_loss_level_i,   // whole %
    input wire logic [7:0] feedback_loss_time_i,    // 0.1 s
    input wire logic [10:0] sleep_start_level_i,    // 0.1 Hz
    input wire logic [7:0] sleep_delay_time_i,      // 0.1 s
    input wire logic [7:0] setpoint_ramp_time_i,    // 0.1 s
    input wire logic stored_setpoint_enable_i,      // use stored setpoint
    input wire logic [15:0] stored_setpoint_value_i, // 0.01 %
    input wire logic [15:0] display_scaling_i,      // monitor scaling
    input wire logic [1:0] sleep_source_select_i,   // sleep source
    input wire logic [6:0] snooze_level_i,          // whole %
    input wire logic [11:0] snooze_delay_time_i,    // seconds
    input wire logic [6:0] snooze_deactivation_level_i, // whole %
    input wire logic [6:0] setpoint_boost_i,        // whole %
    input wire logic [11:0] max_boost_time_i,       // seconds
    input wire logic [6:0] snooze_feedback_level_i, // whole %
    input wire logic [3:0] unit_text_select_i,      // unit text
    input wire logic [3:0] reg_addr_i,              // register index
    input wire logic reg_we_i,                      // register write
    input wire logic [15:0] reg_wdata_i,            // write data
    output logic [15:0] reg_rdata_o,                // read data
    output logic signed [15:0] speed_cmd_o,         // speed command
    output logic run_o,                             // internal run command
    output logic drive_en_o,                        // output drive enable
    output logic fault_relay_output_o,              // fault relay
    output logic loss_alarm_o,                      // feedback loss flag
    output logic asleep_o,                          // sleeping
    output logic snoozing_o,                        // snoozed
    output logic boosting_o,                        // boost in progress
    output logic [15:0] setpoint_o,                 // ramped setpoint
    output logic [15:0] setpoint_monitor_o,         // scaled setpoint
    output logic [15:0] feedback_monitor_o,         // scaled feedback
    output logic [1:0] mon_fmt_o,                   // monitor format
    output logic [2:0] mon_dp_o,                    // decimal places
    output logic [3:0] unit_o                       // unit text shown
);
    // ************************************************************
    // run pin synchroniser and control tick
    // ************************************************************
    logic run_s1, run_s2, run_s3, run_q;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] net_sp, net_sel;
    // three stages; a change counts once stages two and three agree
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
            run_s3 <= 1'b0;
            run_q <= 1'b0;
        end else if (ce_i) begin
            run_s1 <= run_pin_i;
            run_s2 <= run_s1;
            run_s3 <= run_s2;
            if (run_s2 == run_s3) run_q <= run_s3;
        end
    end
    // one pulse per 0.1 s drives every timed setting
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
        end else if (ce_i) begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            if (tick_cnt == 32'(TICK_CYCLES - 1)) tick_cnt <= 32'h0;
            else tick_cnt <= tick_cnt + 32'h1;
        end
    end
    // ************************************************************
    // network registers
    // ************************************************************
    // writes store; reads are registered
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            net_sp <= NET_RST;
            net_sel <= NET_RST;
            reg_rdata_o <= 16'h0000;
        end else if (ce_i) begin
            if (reg_we_i && reg_addr_i == REG_NET_SP) net_sp <= reg_wdata_i;
            if (reg_we_i && reg_addr_i == REG_NET_SEL) net_sel <= reg_wdata_i;
            case (reg_addr_i)
                REG_NET_SP: reg_rdata_o <= net_sp;
                REG_NET_SEL: reg_rdata_o <= net_sel;
                REG_STATUS: reg_rdata_o <= {10'h000, boosting_o, snoozing_o,
                    asleep_o, loss_alarm_o, fault_relay_output_o, run_o};
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end
    // ************************************************************
    // speed command shaping
    // ************************************************************
    logic signed [31:0] pi_scaled, cmd_raw, next_cmd;
    assign pi_scaled = (32'(pi_result_i) * $signed({24'h000000, pi_output_gain_i}))
        / GAIN_DIV;
    // mode picks pi, trim or plain speed; reverse clamp under pi
    always_comb begin
        case (pi_mode_select_i)
            PI_ON: cmd_raw = pi_scaled;
            PI_TRIM: cmd_raw = 32'(speed_ref_i) + pi_scaled;
            default: cmd_raw = 32'(speed_ref_i);
        endcase
        next_cmd = cmd_raw;
        if ((pi_mode_select_i == PI_ON || pi_mode_select_i == PI_TRIM) &&
            !pi_reverse_permit_i && cmd_raw < 0)
            next_cmd = 32'sh0;
    end
    // ************************************************************
    // setpoint selection, boost and ramp
    // ************************************************************
    pss_snz_type snz_state;
    logic [15:0] sp_sel, sp_target, ramp_step;
    logic [31:0] boost_sum;
    always_comb begin
        if (stored_setpoint_enable_i && !diff_mode_i)
            sp_sel = stored_setpoint_value_i;
        else if (net_sel[NET_SEL_BIT])
            sp_sel = net_sp;
        else
            sp_sel = speed_ref_i[15] ? 16'h0000 : speed_ref_i;
        boost_sum = 32'(sp_sel) + 32'(setpoint_boost_i) * PCT_MUL;
        sp_target = (snz_state == PSS_BOOST) ? boost_sum[15:0] : sp_sel;
        ramp_step = (setpoint_ramp_time_i == 8'h00) ? 16'hFFFF :
            16'(FULL_PCT / int'(setpoint_ramp_time_i));
        if (ramp_step == 16'h0000) ramp_step = 16'h0001;
    end
    // setpoint walks toward target one step per tick
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            setpoint_o <= 16'h0000;
        end else if (ce_i && tick) begin
            if (setpoint_o < sp_target)
                setpoint_o <= (sp_target - setpoint_o > ramp_step) ?
                    setpoint_o + ramp_step : sp_target;
            else
                setpoint_o <= (setpoint_o - sp_target > ramp_step) ?
                    setpoint_o - ramp_step : sp_target;
        end
    end
    // ************************************************************
    // qualification timers
    // ************************************************************
    logic fb_low, loss_hit, sl_below, sl_cond, sl_done, sleep_on, snz_cond;
    logic snz_done, boost_done, boost_hit;
    logic [7:0] loss_cnt, sl_cnt;
    logic [15:0] snz_cnt, boost_cnt;
    logic [31:0] sl_lvl, sl_val;
    assign fb_low = 32'(feedback_i) < 32'(feedback_loss_level_i) * PCT_MUL;
    assign loss_hit = fb_low && loss_cnt >= feedback_loss_time_i;
    assign sleep_on = sleep_start_level_i != 11'h000 && sleep_source_select_i != SRC_SNZ;
    assign sl_lvl = 32'(sleep_start_level_i) * FULL_PCT / MAX_FREQ_DHZ;
    assign sl_val = (sleep_source_select_i == SRC_CMD) ?
        (next_cmd < 0 ? 32'h0 : next_cmd) : 32'(setpoint_o);
    assign sl_below = sl_val < sl_lvl;
    assign sl_cond = sleep_on && (asleep_o ? (sl_val > sl_lvl) : sl_below);
    assign sl_done = sl_cond && sl_cnt >= sleep_delay_time_i;
    assign snz_cond = sleep_source_select_i == SRC_SNZ &&
        32'(out_freq_i) < 32'(snooze_level_i) * PCT_MUL &&
        32'(feedback_i) > 32'(snooze_feedback_level_i) * PCT_MUL;
    assign snz_done = snz_cond && 32'(snz_cnt) >= 32'(snooze_delay_time_i) * TICKS_PER_S;
    assign boost_done = 32'(boost_cnt) >= 32'(max_boost_time_i) * TICKS_PER_S;
    assign boost_hit = 32'(feedback_i) >= boost_sum;
    // each timer restarts whenever its condition drops
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) loss_cnt <= 8'h00;
        else if (ce_i) begin
            if (!fb_low) loss_cnt <= 8'h00;
            else if (tick && loss_cnt != 8'hFF) loss_cnt <= loss_cnt + 8'h01;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) sl_cnt <= 8'h00;
        else if (ce_i) begin
            if (!sl_cond || sl_done) sl_cnt <= 8'h00;
            else if (tick) sl_cnt <= sl_cnt + 8'h01;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) snz_cnt <= 16'h0000;
        else if (ce_i) begin
            if (!snz_cond || snz_state != PSS_NORM) snz_cnt <= 16'h0000;
            else if (tick && snz_cnt != 16'hFFFF) snz_cnt <= snz_cnt + 16'h0001;
        end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) boost_cnt <= 16'h0000;
        else if (ce_i) begin
            if (snz_state != PSS_BOOST) boost_cnt <= 16'h0000;
            else if (tick && boost_cnt != 16'hFFFF) boost_cnt <= boost_cnt + 16'h0001;
        end
    end
    // ************************************************************
    // sleep, snooze and loss state
    // ************************************************************
    // sleep toggles when its qualified condition completes
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) asleep_o <= 1'b0;
        else if (ce_i) begin
            if (!sleep_on) asleep_o <= 1'b0;
            else if (sl_done) asleep_o <= !asleep_o;
        end
    end
    // snooze: normal, boost, snoozed
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) snz_state <= PSS_NORM;
        else if (ce_i) begin
            if (sleep_source_select_i != SRC_SNZ) snz_state <= PSS_NORM;
            else case (snz_state)
                PSS_NORM: if (snz_done)
                    snz_state <= (setpoint_boost_i != 7'h00) ? PSS_BOOST : PSS_SNZ;
                PSS_BOOST: if (boost_hit || boost_done) snz_state <= PSS_SNZ;
                PSS_SNZ: if (32'(feedback_i) < 32'(snooze_deactivation_level_i) * PCT_MUL)
                    snz_state <= PSS_NORM;
                default: snz_state <= PSS_NORM;
            endcase
        end
    end
    // loss flag follows response; fault latches, set beats clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loss_alarm_o <= 1'b0;
            fault_relay_output_o <= 1'b0;
        end else if (ce_i) begin
            loss_alarm_o <= loss_hit && feedback_loss_response_i != LOSS_OFF;
            if (loss_hit && feedback_loss_response_i == LOSS_FLT)
                fault_relay_output_o <= 1'b1;
            else if (fault_reset_i) fault_relay_output_o <= 1'b0;
        end
    end
    // ************************************************************
    // outputs and monitors
    // ************************************************************
    function automatic logic [15:0] pss_disp(input logic [15:0] pct, input logic [15:0] sc);
        logic [31:0] v;
        v = 32'h0;
        if (sc == DISP_HZ) v = 32'(pct) * 32'(MAX_FREQ_DHZ) / HZ_DIV;
        else if (sc == DISP_PCT) v = 32'(pct);
        else if (sc < DISP_ENG) v = 32'(pct) * 32'(MAX_FREQ_DHZ) * RPM_MUL / (RPM_DIV * 32'(sc));
        else v = 32'(pct) * (32'(sc) % ENG_DIV) / FULL_PCT;
        return v[15:0];
    endfunction
    // drive and run gating; pi, loss and monitors keep running while asleep
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            speed_cmd_o <= 16'sh0000;
            run_o <= 1'b0;
            drive_en_o <= 1'b0;
            snoozing_o <= 1'b0;
            boosting_o <= 1'b0;
        end else if (ce_i) begin
            speed_cmd_o <= next_cmd[15:0];
            run_o <= run_q && !asleep_o && !fault_relay_output_o;
            drive_en_o <= run_q && !asleep_o && !fault_relay_output_o &&
                snz_state != PSS_SNZ;
            snoozing_o <= snz_state == PSS_SNZ;
            boosting_o <= snz_state == PSS_BOOST;
        end
    end
    // scaling only reshapes what the monitors show
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            setpoint_monitor_o <= 16'h0000;
            feedback_monitor_o <= 16'h0000;
            mon_fmt_o <= FMT_PCT;
            mon_dp_o <= 3'h0;
            unit_o <= 4'h0;
        end else if (ce_i) begin
            setpoint_monitor_o <= pss_disp(setpoint_o, display_scaling_i);
            feedback_monitor_o <= pss_disp(feedback_i, display_scaling_i);
            unit_o <= unit_text_select_i;
            mon_dp_o <= (display_scaling_i >= DISP_ENG) ?
                3'(32'(display_scaling_i) / ENG_DIV) : 3'h0;
            if (display_scaling_i == DISP_HZ) mon_fmt_o <= FMT_HZ;
            else if (display_scaling_i == DISP_PCT) mon_fmt_o <= FMT_PCT;
            else if (display_scaling_i < DISP_ENG) mon_fmt_o <= FMT_RPM;
            else mon_fmt_o <= FMT_ENG;
        end
    end
    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_no_reverse;
        ce_i && (pi_mode_select_i == PI_ON || pi_mode_select_i == PI_TRIM) &&
            !pi_reverse_permit_i |=> !speed_cmd_o[15];
    endproperty
    a_no_reverse: assert property (p_no_reverse) else $error("reverse under pi");
    property p_alarm_only;
        ce_i && feedback_loss_response_i == LOSS_ALM && !fault_relay_output_o
            && !fault_reset_i |=> !fault_relay_output_o;
    endproperty
    a_alarm_only: assert property (p_alarm_only) else $error("alarm set relay");
    property p_fault_coast;
        ce_i && loss_hit && feedback_loss_response_i == LOSS_FLT
            |=> fault_relay_output_o ##1 !drive_en_o || !ce_i;
    endproperty
    a_fault_coast: assert property (p_fault_coast) else $error("fault no coast");
    property p_loss_cause;
        $rose(loss_alarm_o) |-> $past(fb_low);
    endproperty
    a_loss_cause: assert property (p_loss_cause) else $error("loss w/o low fb");
    property p_sleep_off;
        ce_i && sleep_start_level_i == 11'h000 |=> !asleep_o;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep while off");
    property p_asleep_stop;
        ce_i && asleep_o |=> !run_o && !drive_en_o;
    endproperty
    a_asleep_stop: assert property (p_asleep_stop) else $error("asleep drives");
    property p_snz_wake;
        ce_i && snz_state == PSS_SNZ && sleep_source_select_i == SRC_SNZ &&
            32'(feedback_i) < 32'(snooze_deactivation_level_i) * PCT_MUL
            |=> snz_state == PSS_NORM;
    endproperty
    a_snz_wake: assert property (p_snz_wake) else $error("snooze wake late");
    property p_boost_to;
        ce_i && snz_state == PSS_BOOST && boost_done && sleep_source_select_i == SRC_SNZ
            |=> snz_state == PSS_SNZ;
    endproperty
    a_boost_to: assert property (p_boost_to) else $error("boost no timeout");
    property p_ramp_zero;
        ce_i && tick && setpoint_ramp_time_i == 8'h00 |=> setpoint_o == $past(sp_target);
    endproperty
    a_ramp_zero: assert property (p_ramp_zero) else $error("step not applied");
    c_sleep: cover property ($rose(asleep_o));
    c_boost_snz: cover property (snz_state == PSS_BOOST ##1 snz_state == PSS_SNZ);
    c_fault: cover property ($rose(fault_relay_output_o));
endmodule

/* tb/pss_plant.sv */
// motor stage and transmitter model facing the supervisor
// assumes the supervisor's core clock; feedback level set by bench
`timescale 1ns/1ps
module pss_plant (
    input wire logic core_clk_i, // core clock
    input wire logic drive_en_i, // output drive on
    input wire logic signed [15:0] speed_cmd_i, // speed command
    input wire logic [15:0] fb_set_i, // process level
    output logic [15:0] out_freq_o, // motor frequency
    output logic [15:0] feedback_o // transmitter output
);
    // motor coasts to zero without drive, never runs backwards
    always_ff @(posedge core_clk_i) begin
        out_freq_o <= (drive_en_i && speed_cmd_i > 0) ? speed_cmd_i : 16'h0000;
        feedback_o <= fb_set_i;
    end
endmodule

/* tb/pss_testbench.sv */
// self-checking bench for the pi sleep and snooze supervisor
// assumes pss_pkg and the plant model are compiled first
`timescale 1ns/1ps
module testbench import pss_pkg::*;;
    logic core_clk_i = 0, nrst_i = 0, ce_i = 1, run_pin_i = 0, fault_reset_i = 0;
    logic reg_we_i = 0, diff_mode_i = 0, pi_reverse_permit_i = 0, stored_setpoint_enable_i = 0;
    logic signed [15:0] pi_result_i = 0, speed_ref_i = 0, speed_cmd_o;
    logic [15:0] stored_setpoint_value_i = 0, display_scaling_i = 1, reg_wdata_i = 0, fb = 0;
    logic [15:0] feedback_i, out_freq_i, reg_rdata_o, setpoint_o, setpoint_monitor_o;
    logic [15:0] feedback_monitor_o, obs, e, d, x;
    logic [1:0] pi_mode_select_i = 1, feedback_loss_response_i = 0, sleep_source_select_i = 1;
    logic [7:0] pi_output_gain_i = 10, feedback_loss_time_i = 0, sleep_delay_time_i = 0;
    logic [7:0] setpoint_ramp_time_i = 0;
    logic [6:0] feedback_loss_level_i = 0, snooze_level_i = 0, snooze_deactivation_level_i = 0;
    logic [6:0] setpoint_boost_i = 0, snooze_feedback_level_i = 60;
    logic [10:0] sleep_start_level_i = 0;
    logic [11:0] snooze_delay_time_i = 0, max_boost_time_i = 0;
    logic [3:0] unit_text_select_i = 0, reg_addr_i = 0, unit_o;
    logic run_o, drive_en_o, fault_relay_output_o, loss_alarm_o, asleep_o, snoozing_o, boosting_o;
    logic [1:0] mon_fmt_o;
    logic [2:0] mon_dp_o;
    logic [15:0] exp_q[$];
    logic [15:0] ds[4] = '{16'h0000, 16'h0001, 16'h0004, 16'h0028};
    int mismatches = 0, comparisons = 0, p, g;
    event sample_ev;
    pss_supervisor #(.TICK_CYCLES(10)) pss_supervisor_inst (.*);
    pss_plant pss_plant_inst (.core_clk_i, .drive_en_i(drive_en_o), .speed_cmd_i(speed_cmd_o),
        .fb_set_i(fb), .out_freq_o(out_freq_i), .feedback_o(feedback_i));
    // 100 MHz clock and global hang limit
    initial forever #5 core_clk_i = ~core_clk_i;
    initial begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        print_verdict();
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_we_i <= 1;
        @(posedge core_clk_i);
        reg_we_i <= 0;
    endtask
    // note the expectation, hand the observed value to the monitor
    task automatic check(input logic [15:0] v, input logic [15:0] o);
        exp_q.push_back(v);
        obs = o;
        -> sample_ev;
        @(posedge core_clk_i);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // monitor takes the oldest note and compares
    always @(sample_ev) begin
        e = exp_q.pop_front();
        comparisons++;
        if (obs !== e) begin
            $display("mismatch at %0t expected %h got %h", $time, e, obs);
            mismatches++;
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'hF4C4));
        repeat (20) @(posedge core_clk_i);
        nrst_i <= 1;
        run_pin_i <= 1;
        for (int s = 0; s < 3; s++) begin
            p = $urandom_range(400);
            g = $urandom_range(250);
            @(posedge core_clk_i);
            pi_result_i <= 16'((s == 0) ? p : -p);
            pi_reverse_permit_i <= (s == 2);
            pi_output_gain_i <= 8'(g);
            repeat (3) @(posedge core_clk_i);
            x = 16'((s == 1) ? 0 : ((s == 0) ? 1 : -1) * (p * g / 10));
            check(x, speed_cmd_o);
        end
        d = 16'($urandom_range(10000));
        wr(REG_NET_SP, d);
        reg_addr_i <= 4'h3;
        repeat (2) @(posedge core_clk_i);
        check(16'h0000, reg_rdata_o);
        reg_addr_i <= REG_NET_SP;
        repeat (2) @(posedge core_clk_i);
        check(d, reg_rdata_o);
        wr(REG_NET_SEL, 16'h0002);
        repeat (30) @(posedge core_clk_i);
        check(d, setpoint_o);
        x = 16'($urandom_range(10000));
        stored_setpoint_value_i <= x;
        stored_setpoint_enable_i <= 1;
        repeat (30) @(posedge core_clk_i);
        check(x, setpoint_o);
        diff_mode_i <= 1;
        repeat (30) @(posedge core_clk_i);
        check(d, setpoint_o);
        foreach (ds[i]) begin
            display_scaling_i <= ds[i];
            repeat (3) @(posedge core_clk_i);
            check(16'(i), 16'(mon_fmt_o));
        end
        feedback_loss_level_i <= 7'h32;
        for (int r = 1; r < 3; r++) begin
            feedback_loss_response_i <= 2'(r);
            repeat (3) @(posedge core_clk_i);
            check(16'(r == 1 ? 3 : 6), 16'({fault_relay_output_o, loss_alarm_o, run_o}));
        end
        fb <= 16'h2710;
        fault_reset_i <= 1;
        repeat (3) @(posedge core_clk_i);
        fault_reset_i <= 0;
        diff_mode_i <= 0;
        stored_setpoint_value_i <= 16'h0000;
        sleep_start_level_i <= 11'h064;
        repeat (40) @(posedge core_clk_i);
        check(16'h0004, 16'({asleep_o, run_o, drive_en_o}));
        sleep_delay_time_i <= 8'h02;
        stored_setpoint_value_i <= 16'h1388;
        repeat (45) @(posedge core_clk_i);
        check(16'h0003, 16'({asleep_o, run_o, drive_en_o}));
        fb <= 16'h1B58;
        feedback_loss_response_i <= 2'h0;
        sleep_source_select_i <= 2'h2;
        snooze_level_i <= 7'h32;
        setpoint_boost_i <= 7'h50;
        max_boost_time_i <= 12'h001;
        display_scaling_i <= 16'h28B9;
        unit_text_select_i <= 4'h9;
        repeat (20) @(posedge core_clk_i);
        check(16'h0003, 16'({snoozing_o, boosting_o, drive_en_o}));
        check(16'h32C8, setpoint_o);
        check(16'h0129, feedback_monitor_o);
        check(16'h0228, setpoint_monitor_o);
        check(16'h0001, 16'(mon_dp_o));
        check(16'h0009, 16'(unit_o));
        repeat (120) @(posedge core_clk_i);
        check(16'h0004, 16'({snoozing_o, boosting_o, drive_en_o}));
        check(16'h1388, setpoint_o);
        fb <= 16'h0BB8;
        snooze_deactivation_level_i <= 7'h28;
        repeat (5) @(posedge core_clk_i);
        check(16'h0001, 16'({snoozing_o, boosting_o, drive_en_o}));
        print_verdict();
    end
endmodule
